// ===== tccu_defs.svh
`ifndef TCCU_DEFS_SVH
`define TCCU_DEFS_SVH

// Widths of the counter, the bus data and the decoded address.
`define TCCU_CNT_W        32
`define TCCU_DATA_W       32
`define TCCU_ADDR_W       12

// Register byte offsets on the peripheral bus.
`define TCCU_OFS_COMPARE      12'h000
`define TCCU_OFS_COMPARE_CTRL 12'h004
`define TCCU_OFS_CAPTURE      12'h008
`define TCCU_OFS_CAPTURE_CTRL 12'h00C
`define TCCU_OFS_STATUS       12'h010

// Compare control field positions and width.
`define TCCU_CMP_EN       0
`define TCCU_CMP_INT_EN   1
`define TCCU_CMP_TXLOAD   2
`define TCCU_CMP_TXSEND   3
`define TCCU_CMP_RXSTART  4
`define TCCU_CMP_RXSTOP   5
`define TCCU_CMP_CTRL_W   6

// Capture control field positions and widths.
`define TCCU_CAP_INT_EN   0
`define TCCU_CAP_SEL_LO   1
`define TCCU_CAP_SEL_HI   6
`define TCCU_CAP_SNAP     7
`define TCCU_CAP_CLEAR    8
`define TCCU_CAP_CTRL_W   7
`define TCCU_CAP_WR_W     9
`define TCCU_CAP_EV_N     5
`define TCCU_CAP_SRC_N    6

// Status register field positions.
`define TCCU_STS_MATCH    0
`define TCCU_STS_CAPTRIG  1

// Reset values.
`define TCCU_RST_CNT      32'h0000_0000
`define TCCU_RST_CMP_CTRL 6'h00
`define TCCU_RST_CAP_CTRL 7'h00
`define TCCU_RST_BIT      1'h0
`define TCCU_ZERO_WORD    32'h0000_0000

`endif

// ===== tccu_pkg.sv
`include "tccu_defs.svh"

package tccu_pkg;
   // Counter sized value shared by compare and capture paths.
   typedef logic [`TCCU_CNT_W-1:0]      tccu_count_t;
   // Bus data word.
   typedef logic [`TCCU_DATA_W-1:0]     tccu_word_t;
   // Compare control bits.
   typedef logic [`TCCU_CMP_CTRL_W-1:0] tccu_cmp_ctrl_t;
   // Stored capture control bits.
   typedef logic [`TCCU_CAP_CTRL_W-1:0] tccu_cap_ctrl_t;
   // Capture control write field including the two command bits.
   typedef logic [`TCCU_CAP_WR_W-1:0]   tccu_cap_wr_t;
   // Radio sequencer done events.
   typedef logic [`TCCU_CAP_EV_N-1:0]   tccu_events_t;
endpackage

// ===== tccu_cap_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "tccu_defs.svh"

interface tccu_cap_if;
   tccu_pkg::tccu_cap_wr_t   wrData;
   logic                     ctrlWrEn;
   tccu_pkg::tccu_count_t    count;
   logic                     tbRise;
   tccu_pkg::tccu_events_t   events;
   tccu_pkg::tccu_count_t    capture;
   tccu_pkg::tccu_cap_ctrl_t ctrlReadback;
   logic                     trigger;
   logic                     intEn;

   // Register block side.
   modport host (output wrData, ctrlWrEn, count, tbRise, events,
                 input capture, ctrlReadback, trigger, intEn);
   // Capture unit side.
   modport unit (input wrData, ctrlWrEn, count, tbRise, events,
                 output capture, ctrlReadback, trigger, intEn);
endinterface

`default_nettype wire

// ===== tccu_capture.sv
`timescale 1ns/100ps
`default_nettype none
`include "tccu_defs.svh"

module tccu_capture (
   // Clock, reset and clock enable.
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clkEn,
   // Register block link.
   tccu_cap_if.unit capIf
);

   tccu_pkg::tccu_cap_ctrl_t ctrlSys_ff;
   tccu_pkg::tccu_cap_ctrl_t nxt_ctrlSys;
   tccu_pkg::tccu_cap_ctrl_t ctrlTb_ff;
   tccu_pkg::tccu_cap_ctrl_t nxt_ctrlTb;
   tccu_pkg::tccu_count_t    capture_ff;
   tccu_pkg::tccu_count_t    nxt_capture;
   logic                     swReq;
   logic                     clrReq;
   logic [`TCCU_CAP_SRC_N-1:0] sources;
   logic                     trigger;

   // Command bits, sources and next state of the capture unit.
   always_comb begin
      swReq   = capIf.ctrlWrEn & capIf.wrData[`TCCU_CAP_SNAP];
      clrReq  = capIf.ctrlWrEn & capIf.wrData[`TCCU_CAP_CLEAR];
      sources = {capIf.events, swReq};
      trigger = |(sources & ctrlSys_ff[`TCCU_CAP_SEL_HI:`TCCU_CAP_SEL_LO]);
      nxt_ctrlSys = ctrlSys_ff;
      if (capIf.ctrlWrEn) begin
         nxt_ctrlSys = capIf.wrData[`TCCU_CAP_CTRL_W-1:0];
      end
      nxt_ctrlTb = capIf.tbRise ? ctrlSys_ff : ctrlTb_ff;
      // The trigger wins over a clear in the same cycle.
      if (trigger) begin
         nxt_capture = capIf.count;
      end else if (clrReq) begin
         nxt_capture = `TCCU_RST_CNT;
      end else begin
         nxt_capture = capture_ff;
      end
   end

   // Capture unit registers, all on the system clock.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlSys_ff <= `TCCU_RST_CAP_CTRL;
         ctrlTb_ff  <= `TCCU_RST_CAP_CTRL;
         capture_ff <= `TCCU_RST_CNT;
      end else if (clkEn) begin
         ctrlSys_ff <= nxt_ctrlSys;
         ctrlTb_ff  <= nxt_ctrlTb;
         capture_ff <= nxt_capture;
      end
   end

   // Outputs back to the register block.
   assign capIf.capture      = capture_ff;
   assign capIf.ctrlReadback = ctrlTb_ff;
   assign capIf.trigger      = trigger;
   assign capIf.intEn        = ctrlTb_ff[`TCCU_CAP_INT_EN];

endmodule // tccu_capture

`default_nettype wire

// ===== tccu_top.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "tccu_defs.svh"

// Notes on behaviour
// - Match is counter equal to timer compare copy, only while timer enable is high.
// - Each radio trigger is its timer enable bit ANDed with match.
// - Match, compare interrupt enable and radio triggers come only from timer-side registers; the capture trigger uses the system select bits.
// - Every setting has a system register and a timer copy taken each timebase rising edge.
// - Compare control has six bits; their timer copies form the readback.
// - Compare value loads from write data; its timer copy is the readback.
// - Compare value and compare control share write data, each with its strobe.
// - Each unit brings out its interrupt enable bit separately.
// - Capture control stores seven bits, each as system and timer pair.
// - Capture control write takes nine bits of write data.
// - Snapshot and clear bits are write-only strobes, absent from readback.
// - Capture trigger ORs each source gated by its select; it is the interrupt.
// - On a clock edge with trigger high the capture register takes the counter.
// - Writing the clear bit zeroes the capture register.
// - Trigger and clear together: the counter value wins.
// - Capture uses a synchronous load enable, never events as clocks.
// - Sources are the software snapshot and five radio sequencer done events.
// - Writing one to the snapshot bit captures at once; zero does nothing.
// - A one enables and a zero disables every enable and select bit.
module tccu_top (
   // Clock, reset and clock enable.
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic                       clkEn,
   // Peripheral bus slave.
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [`TCCU_ADDR_W-1:0]    paddr,
   input  wire logic [`TCCU_DATA_W-1:0]    pwdata,
   output logic      [`TCCU_DATA_W-1:0]    prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Timebase.
   input  wire logic                       timebase_clk,
   input  wire logic [`TCCU_CNT_W-1:0]     count,
   // Radio sequencer done events.
   input  wire logic                       txLoadDone,
   input  wire logic                       txSfdDone,
   input  wire logic                       txSendDone,
   input  wire logic                       rxSfdDone,
   input  wire logic                       rxDone,
   // Compare unit outputs.
   output logic                            cmpMatch,
   output logic                            cmpIntEn,
   output logic                            txLoadTrigger,
   output logic                            txSendTrigger,
   output logic                            rxStartTrigger,
   output logic                            rxStopTrigger,
   output logic      [`TCCU_CNT_W-1:0]     cmpValue,
   output logic      [`TCCU_CMP_CTRL_W-1:0] cmpCtrl,
   // Capture unit outputs.
   output logic                            capTrigger,
   output logic                            capIntEn,
   output logic      [`TCCU_CNT_W-1:0]     capValue,
   output logic      [`TCCU_CAP_CTRL_W-1:0] capCtrl
);

   // True when the bus address selects the given register word.
   function automatic logic regHit(input logic [`TCCU_ADDR_W-1:0] addr,
                                   input logic [`TCCU_ADDR_W-1:0] ofs);
      regHit = (addr == ofs);
   endfunction

   // A radio trigger follows match only while its own timer-side enable is set.
   function automatic logic gateTrig(input logic enBit,
                                     input logic hit);
      gateTrig = enBit & hit;
   endfunction

   // Timebase edge detection.
   // The pin is treated as data, not as a clock: no logic runs on its edges.
   logic tbPrev_ff;
   logic nxt_tbPrev;
   logic tbRise;

   // Compare unit state.
   tccu_pkg::tccu_count_t    cmpSys_ff;
   tccu_pkg::tccu_count_t    nxt_cmpSys;
   tccu_pkg::tccu_count_t    cmpTb_ff;
   tccu_pkg::tccu_count_t    nxt_cmpTb;
   tccu_pkg::tccu_cmp_ctrl_t cmpCtrlSys_ff;
   tccu_pkg::tccu_cmp_ctrl_t nxt_cmpCtrlSys;
   tccu_pkg::tccu_cmp_ctrl_t cmpCtrlTb_ff;
   tccu_pkg::tccu_cmp_ctrl_t nxt_cmpCtrlTb;
   logic                     match;

   // Bus slave state.
   // The armed flop marks a pending transfer cycle, setup or access, that was seen with the clock enabled.
   logic                     armed_ff;
   logic                     nxt_armed;
   tccu_pkg::tccu_word_t     prdata_ff;
   tccu_pkg::tccu_word_t     nxt_prdata;
   logic                     slvErr_ff;
   logic                     nxt_slvErr;
   logic                     setupPhase;
   logic                     writeDone;
   logic                     mapped;
   tccu_pkg::tccu_word_t     readMux;
   tccu_pkg::tccu_word_t     statusWord;
   logic                     cmpWrEn;
   logic                     cmpCtrlWrEn;
   logic                     capCtrlWrEn;

   // Link to the capture unit.
   // It carries the write field, counter, timebase rise and events inward,
   // and the capture value, readback, trigger and interrupt enable outward.
   tccu_cap_if capIf ();

   // The timebase pin is sampled like any other synchronous input.
   // A rising edge is a cycle where it is high and was low one cycle earlier.
   // The pin must stay high and low for at least one system clock each, or a
   // rise is missed and the timer copies wait one more timebase period.
   always_comb begin
      nxt_tbPrev = timebase_clk;
      tbRise     = timebase_clk & ~tbPrev_ff;
   end

   // Register the previous timebase level.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tbPrev_ff <= `TCCU_RST_BIT;
      end else if (clkEn) begin
         tbPrev_ff <= nxt_tbPrev;
      end
   end

   // Bus phase decoding and the write strobes for each register.
   // A write lands only on the access edge at which ready is high.
   // Writes to the capture word or the status word raise no strobe and are dropped.
   always_comb begin
      setupPhase  = psel & ~penable;
      writeDone   = psel & penable & pready & pwrite;
      cmpWrEn     = writeDone & regHit(paddr, `TCCU_OFS_COMPARE);
      cmpCtrlWrEn = writeDone & regHit(paddr, `TCCU_OFS_COMPARE_CTRL);
      capCtrlWrEn = writeDone & regHit(paddr, `TCCU_OFS_CAPTURE_CTRL);
      mapped      = regHit(paddr, `TCCU_OFS_COMPARE)
                  | regHit(paddr, `TCCU_OFS_COMPARE_CTRL)
                  | regHit(paddr, `TCCU_OFS_CAPTURE)
                  | regHit(paddr, `TCCU_OFS_CAPTURE_CTRL)
                  | regHit(paddr, `TCCU_OFS_STATUS);
   end

   // Next values of the compare registers.
   // The system copy follows the bus, the timer copy follows the system copy.
   // A write reaches the timer side only at the next timebase rise, so a read
   // made at once still returns the old value.
   always_comb begin
      nxt_cmpSys = cmpSys_ff;
      if (cmpWrEn) begin
         nxt_cmpSys = pwdata[`TCCU_CNT_W-1:0];
      end
      nxt_cmpCtrlSys = cmpCtrlSys_ff;
      if (cmpCtrlWrEn) begin
         nxt_cmpCtrlSys = pwdata[`TCCU_CMP_CTRL_W-1:0];
      end
      // Timer copies refresh on every timebase rising edge.
      nxt_cmpTb     = tbRise ? cmpSys_ff : cmpTb_ff;
      nxt_cmpCtrlTb = tbRise ? cmpCtrlSys_ff : cmpCtrlTb_ff;
   end

   // Compare registers of both sides.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cmpSys_ff     <= `TCCU_RST_CNT;
         cmpTb_ff      <= `TCCU_RST_CNT;
         cmpCtrlSys_ff <= `TCCU_RST_CMP_CTRL;
         cmpCtrlTb_ff  <= `TCCU_RST_CMP_CTRL;
      end else if (clkEn) begin
         cmpSys_ff     <= nxt_cmpSys;
         cmpTb_ff      <= nxt_cmpTb;
         cmpCtrlSys_ff <= nxt_cmpCtrlSys;
         cmpCtrlTb_ff  <= nxt_cmpCtrlTb;
      end
   end

   // Match logic looks only at the timer copies and the counter.
   // A disabled unit never reports a match.
   // Match is a level that stands as long as the counter holds the value; with
   // a slow timebase it spans several system clocks.
   always_comb begin
      match = cmpCtrlTb_ff[`TCCU_CMP_EN] & (count == cmpTb_ff);
   end

   // Compare unit outputs; match and the radio triggers gated by it come from timer-side registers.
   // The interrupt itself is formed outside, from match and the enable output.
   // Triggers are levels and stand for as long as match does.
   assign cmpMatch       = match;
   assign cmpIntEn       = cmpCtrlTb_ff[`TCCU_CMP_INT_EN];
   assign txLoadTrigger  = gateTrig(cmpCtrlTb_ff[`TCCU_CMP_TXLOAD], match);
   assign txSendTrigger  = gateTrig(cmpCtrlTb_ff[`TCCU_CMP_TXSEND], match);
   assign rxStartTrigger = gateTrig(cmpCtrlTb_ff[`TCCU_CMP_RXSTART], match);
   assign rxStopTrigger  = gateTrig(cmpCtrlTb_ff[`TCCU_CMP_RXSTOP], match);
   assign cmpValue       = cmpTb_ff;
   assign cmpCtrl        = cmpCtrlTb_ff;

   // Feed the capture unit from the bus and the event pins.
   // Only nine bits of the write word reach the capture control.
   // Clear and snapshot arrive only with the write strobe, so a read never
   // disturbs the capture register.
   assign capIf.wrData   = pwdata[`TCCU_CAP_WR_W-1:0];
   assign capIf.ctrlWrEn = capCtrlWrEn;
   assign capIf.count    = count;
   assign capIf.tbRise   = tbRise;
   // Event pulses must stand for a full clock to be seen.
   assign capIf.events   = {rxDone, rxSfdDone, txSendDone, txSfdDone, txLoadDone};

   // Capture unit instance.
   // The unit runs on the system clock and shares the clock enable, so a
   // frozen block neither captures nor clears.
   tccu_capture u_capture (
      .clk     (clk),
      .reset_n (reset_n),
      .clkEn   (clkEn),
      .capIf   (capIf.unit)
   );

   // Capture unit outputs.
   assign capTrigger = capIf.trigger;
   assign capIntEn   = capIf.intEn;
   assign capValue   = capIf.capture;
   assign capCtrl    = capIf.ctrlReadback;

   // Status word: live match and capture trigger, every other bit zero.
   // Both bits are levels, so a read sees them only while they stand.
   always_comb begin
      statusWord                    = `TCCU_ZERO_WORD;
      statusWord[`TCCU_STS_MATCH]   = match;
      statusWord[`TCCU_STS_CAPTRIG] = capIf.trigger;
   end

   // Read data selection; reserved bits and unmapped words read as zero.
   // Every register reads its timer-side copy except capture and status,
   // which have no timer copy.
   always_comb begin
      readMux = `TCCU_ZERO_WORD;
      case (paddr)
         `TCCU_OFS_COMPARE: begin
            readMux = cmpTb_ff;
         end
         `TCCU_OFS_COMPARE_CTRL: begin
            readMux[`TCCU_CMP_CTRL_W-1:0] = cmpCtrlTb_ff;
         end
         `TCCU_OFS_CAPTURE: begin
            readMux = capIf.capture;
         end
         `TCCU_OFS_CAPTURE_CTRL: begin
            readMux[`TCCU_CAP_CTRL_W-1:0] = capIf.ctrlReadback;
         end
         `TCCU_OFS_STATUS: begin
            readMux = statusWord;
         end
         default: begin
            readMux = `TCCU_ZERO_WORD;
         end
      endcase
   end

   // Bus slave next state.
   // Unmapped or misaligned words answer with an error but with no wait state.
   // Read data and error are caught in the setup cycle so that they come
   // from flip-flops in the access phase; ready then follows one cycle on.
   always_comb begin
      nxt_armed  = psel & ~(penable & pready);
      nxt_prdata = prdata_ff;
      nxt_slvErr = slvErr_ff;
      if (setupPhase) begin
         nxt_prdata = pwrite ? `TCCU_ZERO_WORD : readMux;
         nxt_slvErr = ~mapped;
      end
   end

   // Bus slave registers.
   // Read data is latched at the setup edge, so a value that changes during
   // the access phase shows only at the next read.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         armed_ff  <= `TCCU_RST_BIT;
         prdata_ff <= `TCCU_ZERO_WORD;
         slvErr_ff <= `TCCU_RST_BIT;
      end else if (clkEn) begin
         armed_ff  <= nxt_armed;
         prdata_ff <= nxt_prdata;
         slvErr_ff <= nxt_slvErr;
      end
   end

   // Ready is held low while the clock enable freezes the block.
   // Ready is combinational so that the access phase takes a single cycle.
   // The error flag is shown only together with ready, never on its own.
   assign pready  = clkEn & penable & armed_ff;
   assign prdata  = prdata_ff;
   assign pslverr = slvErr_ff & pready;

endmodule // tccu_top

`default_nettype wire

// ===== tccu_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module tccu_top_asserts (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        clkEn,
   // Bus, timebase and sources.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timebase_clk,
   input wire logic [31:0] count,
   input wire logic [4:0]  ev,
   // Watched outputs.
   input wire logic        cmpMatch,
   input wire logic        cmpIntEn,
   input wire logic [3:0]  trig,
   input wire logic [31:0] cmpValue,
   input wire logic [5:0]  cmpCtrl,
   input wire logic        capTrigger,
   input wire logic        capIntEn,
   input wire logic [31:0] capValue,
   input wire logic [6:0]  capCtrl
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic tbPrev_ff;
   logic nxt_tbPrev;
   logic tbRise;
   // Remember the timebase level to spot its rise.
   always_comb nxt_tbPrev = timebase_clk;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) tbPrev_ff <= 1'h0;
      else if (clkEn) tbPrev_ff <= nxt_tbPrev;
   end
   assign tbRise = timebase_clk & ~tbPrev_ff;
   AST_MATCH: assert property (cmpMatch == (cmpCtrl[0] && count == cmpValue))
      else $error("Match output wrong.");
   AST_TRIG: assert property (trig == (cmpCtrl[5:2] & {4{cmpMatch}}))
      else $error("Radio trigger wrong.");
   AST_INTEN: assert property (cmpIntEn == cmpCtrl[1] && capIntEn == capCtrl[0])
      else $error("Interrupt enable output wrong.");
   AST_COPY: assert property (!$stable({cmpCtrl, cmpValue, capCtrl}) |-> $past(tbRise))
      else $error("Timer copy changed off a timebase rise.");
   AST_CAPLOAD: assert property (capTrigger && clkEn |=> capValue == $past(count))
      else $error("Capture did not load the counter.");
   AST_CAPZERO: assert property (!$stable(capValue) && !$past(capTrigger) |-> capValue == 32'h0)
      else $error("Capture changed to nonzero without trigger.");
   AST_SRC: assert property (capTrigger |-> (|ev) || psel || $past(psel))
      else $error("Capture trigger without a source.");
   AST_PREADY: assert property (pready |-> (psel && penable) ##1 !pready)
      else $error("Ready outside a single access cycle.");
   AST_ERR: assert property (pslverr |-> pready)
      else $error("Error response without ready.");
   // Main scenarios.
   cover property (capTrigger);
   cover property (trig[0]);
   cover property (pslverr);
endmodule // tccu_top_asserts
bind tccu_top tccu_top_asserts u_asserts (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .timebase_clk(timebase_clk),
   .count(count), .ev({rxDone, rxSfdDone, txSendDone, txSfdDone, txLoadDone}),
   .cmpMatch(cmpMatch), .cmpIntEn(cmpIntEn),
   .trig({rxStopTrigger, rxStartTrigger, txSendTrigger, txLoadTrigger}),
   .cmpValue(cmpValue), .cmpCtrl(cmpCtrl), .capTrigger(capTrigger), .capIntEn(capIntEn),
   .capValue(capValue), .capCtrl(capCtrl));
`default_nettype wire

// ===== tccu_radio_model.sv
`timescale 1ns/100ps
`default_nettype none
module tccu_radio_model (
   // Clock and control.
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        run,
   input  wire logic [4:0]  evReq,
   // Timebase and done events.
   output logic             timebase_clk,
   output logic [31:0]      count,
   output logic [4:0]       events
);
   logic [1:0]  phase_ff, nxt_phase;
   logic [31:0] count_ff, nxt_count;
   logic [4:0]  events_ff;
   // Timebase runs free at a quarter of clk; the counter steps on its rise while enabled.
   always_comb begin
      nxt_phase = phase_ff + 2'h1;
      nxt_count = (run && phase_ff == 2'h1) ? count_ff + 32'h1 : count_ff;
   end
   // Each requested event is a pulse one full system cycle long.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_ff  <= 2'h0;
         count_ff  <= 32'h10;
         events_ff <= 5'h0;
      end else begin
         phase_ff  <= nxt_phase;
         count_ff  <= nxt_count;
         events_ff <= evReq;
      end
   end
   assign timebase_clk = phase_ff[1];
   assign count = count_ff;
   assign events = events_ff;
endmodule // tccu_radio_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, count, capValue, cmpValue;
   logic pready, pslverr, er, run = 1'h0, tbClk, cmpMatch, cmpIntEn, capTrigger, capIntEn;
   logic clkEn = 1'h1;
   logic [4:0] evReq = 5'h0, ev;
   logic [3:0] trig;
   logic [5:0] cmpCtrl;
   logic [6:0] capCtrl;
   int error_cnt = 0, n_checks = 0, k;
   // Design under test with its radio and timebase partner.
   tccu_top DUT (.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timebase_clk(tbClk), .count(count), .txLoadDone(ev[0]),
      .txSfdDone(ev[1]), .txSendDone(ev[2]), .rxSfdDone(ev[3]), .rxDone(ev[4]),
      .cmpMatch(cmpMatch), .cmpIntEn(cmpIntEn), .txLoadTrigger(trig[0]),
      .txSendTrigger(trig[1]), .rxStartTrigger(trig[2]), .rxStopTrigger(trig[3]),
      .cmpValue(cmpValue), .cmpCtrl(cmpCtrl), .capTrigger(capTrigger), .capIntEn(capIntEn),
      .capValue(capValue), .capCtrl(capCtrl));
   tccu_radio_model u_radio (.clk(clk), .reset_n(reset_n), .run(run), .evReq(evReq),
      .timebase_clk(tbClk), .count(count), .events(ev));
   // Clock at 40 MHz.
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Prints the verdict and ends the run.
   task automatic report_and_stop();
      if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Compares one result and counts it.
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer, entered right after a rising edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'h1 && k < 50);
      if (k >= 50) begin
         error_cnt++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   // Lets a number of cycles pass.
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Main sequence.
   initial begin
      idle(3);
      reset_n <= 1'h1;
      idle(2);
      chk("reset", 32'h0, cmpValue | capValue);
      chk("reset ctrl", 32'h0, {19'h0, cmpCtrl, capCtrl});
      chk("reset bus", 32'h0, {prdata[30:0], pready | pslverr | cmpMatch});
      run <= 1'h1;
      apb(1'h1, 12'h000, 32'h30);
      apb(1'h1, 12'h004, 32'h7);
      idle(8);
      chk("cmpValue", 32'h30, cmpValue);
      chk("cmpCtrl", 32'h7, {26'h0, cmpCtrl});
      chk("cmpIntEn", 32'h1, {31'h0, cmpIntEn});
      apb(1'h0, 12'h004, 32'h0);
      chk("cmpCtrl read", 32'h7, rd);
      k = 0;
      while (cmpMatch !== 1'h1 && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (k >= 400) begin
         error_cnt++;
         report_and_stop();
      end
      chk("trig at match", 32'h1, {28'h0, trig});
      apb(1'h0, 12'h010, 32'h0);
      chk("status", 32'h1, rd);
      run <= 1'h0;
      idle(8);
      apb(1'h1, 12'h00C, 32'h17E);
      chk("cleared", 32'h0, capValue);
      idle(8);
      apb(1'h0, 12'h00C, 32'h0);
      chk("capCtrl read", 32'h7E, rd);
      chk("capCtrl", 32'h7E, {25'h0, capCtrl});
      for (int i = 0; i < 5; i++) begin
         apb(1'h1, 12'h00C, 32'h17E);
         chk("cleared", 32'h0, capValue);
         evReq <= 5'h1 << i;
         @(posedge clk);
         evReq <= 5'h0;
         idle(3);
         chk("event capture", count, capValue);
      end
      apb(1'h1, 12'h00C, 32'h103);
      evReq <= 5'h10;
      @(posedge clk);
      evReq <= 5'h0;
      idle(3);
      chk("unselected", 32'h0, capValue);
      chk("capIntEn", 32'h1, {31'h0, capIntEn});
      apb(1'h1, 12'h00C, 32'h182);
      idle(2);
      chk("snapshot", count, capValue);
      apb(1'h1, 12'h00C, 32'h002);
      idle(2);
      chk("snapshot zero", count, capValue);
      apb(1'h0, 12'h008, 32'h0);
      chk("capture read", count, rd);
      apb(1'h0, 12'h014, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], er});
      clkEn <= 1'h0;
      fork
         apb(1'h1, 12'h000, 32'h55);
         begin
            idle(4);
            chk("frozen ready", 32'h0, {31'h0, pready});
            clkEn <= 1'h1;
         end
      join
      idle(8);
      apb(1'h0, 12'h000, 32'h0);
      chk("cmpValue read", 32'h55, rd);
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
